//--- pif_pkg.sv
// Purpose: constants and types for the peripheral flag and reset-cause block
// Assumes: APB slave, 32-bit data, 8-bit registers in the low byte
// Notes: offsets of both registers and of the mask register are local choices
//
// What this block does
// R1 - Each flag sets on its event regardless of any enable bit.
// R2 - Software clears flags before enabling and after servicing an interrupt.
// R3 - Only the first of three peripheral flag registers is implemented here.
// R4 - Parallel port flag, bit 7, sets on port access, held until cleared.
// R5 - Converter flag, bit 6, sets on conversion done, software clears it.
// R6 - Serial receive flag, bit 5, read-only, mirrors receive buffer full.
// R7 - Serial transmit flag, bit 4, read-only, mirrors transmit buffer empty.
// R8 - Sync serial flag, bit 3, sets on transfer done, software clears it.
// R9 - Capture mode: capture/compare flag, bit 2, sets on timer capture.
// R10 - Compare mode: same flag sets on match; unused in PWM mode.
// R11 - Period match flag, bit 1, sets when timer count equals period.
// R12 - Timer overflow flag, bit 0, sets on overflow, software clears it.
// R13 - Reset-cause bit 7 enables interrupt priority levels when set.
// R14 - Reset-cause register records reset instruction, watchdog, power-down, BOR; the POR bit is set only by software writes.
// R15 - Reset-cause bit 5 is unimplemented and reads zero.
// R16 - Writes to read-only flags are ignored; writable flags take written value.
package pif_pkg;
    localparam logic [7:0] PIF_OFF_FLAG1 = 8'h00;
    localparam logic [7:0] PIF_OFF_RCAUSE = 8'h04;
    localparam logic [7:0] PIF_OFF_MASK = 8'h08;
    localparam logic [7:0] PIF_OFF_ISTAT = 8'h0C;
    // Flag register layout
    localparam int PIF_B_PAR = 7;
    localparam int PIF_B_CONV = 6;
    localparam int PIF_B_RX = 5;
    localparam int PIF_B_TX = 4;
    localparam int PIF_B_SYNC = 3;
    localparam int PIF_B_CAPCMP = 2;
    localparam int PIF_B_PERIOD = 1;
    localparam int PIF_B_OVF = 0;
    localparam logic [7:0] PIF_FLAG_WR_MASK = 8'hCF;
    localparam logic [7:0] PIF_FLAG_RESET = 8'h00;
    // Reset-cause layout
    localparam int PIF_R_PRIO = 7;
    localparam int PIF_R_SBOR = 6;
    localparam int PIF_R_RI = 4;
    localparam int PIF_R_TO = 3;
    localparam int PIF_R_PD = 2;
    localparam int PIF_R_POR = 1;
    localparam int PIF_R_BOR = 0;
    localparam logic [7:0] PIF_RCAUSE_RESET = 8'h5C;
    localparam logic [7:0] PIF_RCAUSE_WR_MASK = 8'hD3;
    localparam logic [7:0] PIF_RCAUSE_IMPL = 8'hDF;
    localparam logic [7:0] PIF_MASK_RESET = 8'h00;
    localparam logic [31:0] PIF_ZERO32 = 32'h0000_0000;

    typedef enum logic [1:0] {
        PIF_CCP_CAPTURE = 2'b00,
        PIF_CCP_COMPARE = 2'b01,
        PIF_CCP_PWM = 2'b10
    } pif_ccp_mode_type;

    // Raw peripheral event strobes, one pulse each
    typedef struct packed {
        logic par_done;
        logic conv_done;
        logic sync_done;
        logic capture;
        logic compare;
        logic period_match;
        logic ovf;
    } pif_events_type;

    // Reset-cause event pulses
    typedef struct packed {
        logic reset_instr;
        logic wdt_timeout;
        logic sleep_entry;
        logic wake;
        logic brownout;
    } pif_rcause_ev_type;
endpackage : pif_pkg

//--- pif_sync.sv
// Purpose: two-flop synchroniser for a bus of levels
// Assumes: inputs are slow levels or stretched pulses
// Notes: first stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module pif_sync #(
    parameter int WIDTH = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : pif_sync
`default_nettype wire

//--- pif_flags.sv
// Purpose: peripheral interrupt flag register 1 and reset-cause register over APB
// Assumes: event strobes and buffer levels come from logic on pclk
// Notes: reset-cause events may come from other domains and are synchronised
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module pif_flags
    import pif_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire pif_events_type events,
    input wire pif_ccp_mode_type ccp_mode,
    input wire logic rx_buf_full,
    input wire logic tx_buf_empty,
    input wire pif_rcause_ev_type rcause_ev,
    output logic prio_enable,
    output logic sw_brownout_enable,
    output logic irq
);
    logic [7:0] flag1;
    logic [7:0] rcause;
    logic [7:0] mask;
    logic [7:0] istat;
    logic [7:0] next_flag1;
    logic [7:0] rise;
    logic [4:0] rc_sync;
    logic [4:0] rc_prev;
    logic [4:0] rc_pulse;
    logic wr_acc;
    logic rd_acc;
    logic rd_acc_q;
    logic [7:0] rd_addr_q;
    logic flag_wr;
    logic rc_wr;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    function automatic logic mapped(input logic [7:0] a);
        mapped = hit(a, PIF_OFF_FLAG1) || hit(a, PIF_OFF_RCAUSE)
            || hit(a, PIF_OFF_MASK) || hit(a, PIF_OFF_ISTAT);
    endfunction : mapped

    assign wr_acc = psel && penable && pwrite && pready;
    assign rd_acc = psel && penable && !pwrite && pready;
    assign flag_wr = wr_acc && hit(paddr, PIF_OFF_FLAG1);
    assign rc_wr = wr_acc && hit(paddr, PIF_OFF_RCAUSE);

    ////////////////////////////////////////////////////////////////////////
    // Reset-cause events cross in from other domains
    pif_sync #(.WIDTH(5)) u_rc_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(rcause_ev),
        .q(rc_sync)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rc_prev <= '0;
        end else begin
            rc_prev <= rc_sync;
        end
    end
    assign rc_pulse = rc_sync & ~rc_prev;

    ////////////////////////////////////////////////////////////////////////
    // Flag register 1
    always_comb begin
        next_flag1 = flag1;
        if (wr_acc && hit(paddr, PIF_OFF_FLAG1)) begin
            next_flag1 = (flag1 & ~PIF_FLAG_WR_MASK) | (pwdata[7:0] & PIF_FLAG_WR_MASK); // R16
        end
        // Sets last so an event beats a same-cycle clear
        if (events.par_done) next_flag1[PIF_B_PAR] = 1'b1; // R4 R1
        if (events.conv_done) next_flag1[PIF_B_CONV] = 1'b1; // R5
        if (events.sync_done) next_flag1[PIF_B_SYNC] = 1'b1; // R8
        if (ccp_mode == PIF_CCP_CAPTURE && events.capture) begin
            next_flag1[PIF_B_CAPCMP] = 1'b1; // R9
        end
        if (ccp_mode == PIF_CCP_COMPARE && events.compare) begin
            next_flag1[PIF_B_CAPCMP] = 1'b1; // R10
        end
        if (events.period_match) next_flag1[PIF_B_PERIOD] = 1'b1; // R11
        if (events.ovf) next_flag1[PIF_B_OVF] = 1'b1; // R12
        // Buffer status bits are live mirrors; the serial block clears them
        next_flag1[PIF_B_RX] = rx_buf_full; // R6
        next_flag1[PIF_B_TX] = tx_buf_empty; // R7
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag1 <= PIF_FLAG_RESET;
        end else begin
            flag1 <= next_flag1; // R3
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset-cause register; status bits are active-low style set/clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rcause <= PIF_RCAUSE_RESET;
        end else begin
            if (wr_acc && hit(paddr, PIF_OFF_RCAUSE)) begin
                rcause <= (rcause & ~PIF_RCAUSE_WR_MASK)
                    | (pwdata[7:0] & PIF_RCAUSE_WR_MASK); // R13
            end
            // Hardware events override a same-cycle write
            if (rc_pulse[4]) rcause[PIF_R_RI] <= 1'b0; // R14
            if (rc_pulse[3]) rcause[PIF_R_TO] <= 1'b0; // R14
            if (rc_pulse[2]) rcause[PIF_R_PD] <= 1'b0; // R14
            if (rc_pulse[1]) rcause[PIF_R_PD] <= 1'b1; // R14
            if (rc_pulse[0]) rcause[PIF_R_BOR] <= 1'b0; // R14
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prio_enable <= PIF_RCAUSE_RESET[PIF_R_PRIO];
            sw_brownout_enable <= PIF_RCAUSE_RESET[PIF_R_SBOR];
        end else begin
            prio_enable <= rcause[PIF_R_PRIO]; // R13
            sw_brownout_enable <= rcause[PIF_R_SBOR];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status, mask and output
    assign rise = next_flag1 & ~flag1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask <= PIF_MASK_RESET;
        end else if (wr_acc && hit(paddr, PIF_OFF_MASK)) begin
            mask <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            istat <= '0;
        end else if (rd_acc && hit(paddr, PIF_OFF_ISTAT)) begin
            istat <= rise; // Read clears, new edge still lands
        end else begin
            istat <= istat | rise;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_istat_f(istat, rise, rd_acc && hit(paddr, PIF_OFF_ISTAT)) & mask);
        end
    end

    function automatic logic [7:0] next_istat_f(input logic [7:0] s, input logic [7:0] r,
                                                input logic clr);
        next_istat_f = clr ? r : (s | r);
    endfunction : next_istat_f

    ////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states, error on unmapped address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped(paddr);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= PIF_ZERO32;
        end else if (psel && !penable && !pwrite) begin
            prdata <= PIF_ZERO32;
            if (hit(paddr, PIF_OFF_FLAG1)) prdata[7:0] <= next_flag1;
            else if (hit(paddr, PIF_OFF_RCAUSE)) prdata[7:0] <= rcause & PIF_RCAUSE_IMPL; // R15
            else if (hit(paddr, PIF_OFF_MASK)) prdata[7:0] <= mask;
            else if (hit(paddr, PIF_OFF_ISTAT)) prdata[7:0] <= istat | rise;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_acc_q <= 1'b0;
            rd_addr_q <= '0;
        end else begin
            rd_acc_q <= rd_acc;
            rd_addr_q <= paddr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    chk_par_set: assert property (@(posedge pclk) disable iff (!presetn) // R4
        events.par_done |=> flag1[PIF_B_PAR])
        else $error("parallel flag not set");
    chk_conv_set: assert property (@(posedge pclk) disable iff (!presetn) // R5
        events.conv_done |=> flag1[PIF_B_CONV])
        else $error("conversion flag not set");
    chk_rx_mirror: assert property (@(posedge pclk) disable iff (!presetn) // R6
        flag1[PIF_B_RX] == $past(rx_buf_full))
        else $error("receive flag does not mirror buffer");
    chk_tx_mirror: assert property (@(posedge pclk) disable iff (!presetn) // R7
        flag1[PIF_B_TX] == $past(tx_buf_empty))
        else $error("transmit flag does not mirror buffer");
    chk_sync_set: assert property (@(posedge pclk) disable iff (!presetn) // R8
        events.sync_done |=> flag1[PIF_B_SYNC])
        else $error("sync serial flag not set");
    chk_pwm_quiet: assert property (@(posedge pclk) disable iff (!presetn) // R10
        (ccp_mode == PIF_CCP_PWM && !flag1[PIF_B_CAPCMP] && !wr_acc)
        |=> !flag1[PIF_B_CAPCMP])
        else $error("capture flag set in PWM mode");
    chk_cap_set: assert property (@(posedge pclk) disable iff (!presetn) // R9
        (ccp_mode == PIF_CCP_CAPTURE && events.capture) |=> flag1[PIF_B_CAPCMP])
        else $error("capture flag not set");
    chk_period_set: assert property (@(posedge pclk) disable iff (!presetn) // R11
        events.period_match |=> flag1[PIF_B_PERIOD])
        else $error("period flag not set");
    chk_ovf_hold: assert property (@(posedge pclk) disable iff (!presetn) // R12
        (flag1[PIF_B_OVF] && !wr_acc) |=> flag1[PIF_B_OVF])
        else $error("overflow flag dropped without write");
    chk_prio_out: assert property (@(posedge pclk) disable iff (!presetn) // R13
        ##1 prio_enable == $past(rcause[PIF_R_PRIO]))
        else $error("priority enable output wrong");
    chk_unimpl_zero: assert property (@(posedge pclk) disable iff (!presetn) // R15
        (rd_acc_q && rd_addr_q == PIF_OFF_RCAUSE) |-> (prdata[7:0] & ~PIF_RCAUSE_IMPL) == 8'h00)
        else $error("unimplemented bit read nonzero");
    chk_ro_write: assert property (@(posedge pclk) disable iff (!presetn) // R16
        (wr_acc && hit(paddr, PIF_OFF_FLAG1)) |=> flag1[PIF_B_RX] == $past(rx_buf_full))
        else $error("write reached read-only flag");
    chk_wdt_cause: assert property (@(posedge pclk) disable iff (!presetn) // R14
        rc_pulse[3] |=> !rcause[PIF_R_TO])
        else $error("watchdog cause not recorded");
    chk_ovf_set: assert property (@(posedge pclk) disable iff (!presetn) // R12
        events.ovf |=> flag1[PIF_B_OVF])
        else $error("overflow flag not set");
    chk_cmp_set: assert property (@(posedge pclk) disable iff (!presetn) // R10
        (ccp_mode == PIF_CCP_COMPARE && events.compare) |=> flag1[PIF_B_CAPCMP])
        else $error("compare flag not set");
    chk_cap_only: assert property (@(posedge pclk) disable iff (!presetn) // R9
        (ccp_mode == PIF_CCP_CAPTURE && !events.capture && !flag1[PIF_B_CAPCMP] && !flag_wr)
        |=> !flag1[PIF_B_CAPCMP])
        else $error("compare event set flag in capture mode");
    chk_cmp_only: assert property (@(posedge pclk) disable iff (!presetn) // R10
        (ccp_mode == PIF_CCP_COMPARE && !events.compare && !flag1[PIF_B_CAPCMP] && !flag_wr)
        |=> !flag1[PIF_B_CAPCMP])
        else $error("capture event set flag in compare mode");

    ////////////////////////////////////////////////////////////////////////
    // Software-clear flags drop only through a flag-register write
    chk_par_hold: assert property (@(posedge pclk) disable iff (!presetn) // R4
        (flag1[PIF_B_PAR] && !flag_wr) |=> flag1[PIF_B_PAR])
        else $error("parallel flag dropped without write");
    chk_conv_hold: assert property (@(posedge pclk) disable iff (!presetn) // R5
        (flag1[PIF_B_CONV] && !flag_wr) |=> flag1[PIF_B_CONV])
        else $error("conversion flag dropped without write");
    chk_sync_hold: assert property (@(posedge pclk) disable iff (!presetn) // R8
        (flag1[PIF_B_SYNC] && !flag_wr) |=> flag1[PIF_B_SYNC])
        else $error("sync serial flag dropped without write");
    chk_capcmp_hold: assert property (@(posedge pclk) disable iff (!presetn) // R9
        (flag1[PIF_B_CAPCMP] && !flag_wr) |=> flag1[PIF_B_CAPCMP])
        else $error("capture flag dropped without write");
    chk_period_hold: assert property (@(posedge pclk) disable iff (!presetn) // R11
        (flag1[PIF_B_PERIOD] && !flag_wr) |=> flag1[PIF_B_PERIOD])
        else $error("period flag dropped without write");
    chk_flag_write: assert property (@(posedge pclk) disable iff (!presetn) // R16
        (flag_wr && events == '0)
        |=> (flag1 & PIF_FLAG_WR_MASK) == ($past(pwdata[7:0]) & PIF_FLAG_WR_MASK))
        else $error("flag write not taken");
    chk_tx_ro: assert property (@(posedge pclk) disable iff (!presetn) // R16
        flag_wr |=> flag1[PIF_B_TX] == $past(tx_buf_empty))
        else $error("write reached transmit flag");
    chk_istat_set: assert property (@(posedge pclk) disable iff (!presetn) // R1
        rise != 8'h00 |=> (istat & $past(rise)) == $past(rise))
        else $error("status bit missed a flag edge");

    ////////////////////////////////////////////////////////////////////////
    // Reset-cause checks; a same-cycle event is left out of the write checks
    chk_rc_write: assert property (@(posedge pclk) disable iff (!presetn) // R13
        (rc_wr && rc_pulse == '0)
        |=> (rcause & PIF_RCAUSE_WR_MASK) == ($past(pwdata[7:0]) & PIF_RCAUSE_WR_MASK))
        else $error("reset-cause write not taken");
    chk_rc_status_ro: assert property (@(posedge pclk) disable iff (!presetn) // R14
        (rc_wr && rc_pulse == '0)
        |=> (rcause & ~PIF_RCAUSE_WR_MASK) == ($past(rcause) & ~PIF_RCAUSE_WR_MASK))
        else $error("write reached read-only cause bit");
    chk_rc_unimpl: assert property (@(posedge pclk) disable iff (!presetn) // R15
        (rcause & ~PIF_RCAUSE_IMPL) == 8'h00)
        else $error("unimplemented cause bit set");
    chk_ri_cause: assert property (@(posedge pclk) disable iff (!presetn) // R14
        rc_pulse[4] |=> !rcause[PIF_R_RI])
        else $error("reset instruction cause not recorded");
    chk_pd_sleep: assert property (@(posedge pclk) disable iff (!presetn) // R14
        (rc_pulse[2] && !rc_pulse[1]) |=> !rcause[PIF_R_PD])
        else $error("power-down cause not recorded");
    chk_pd_wake: assert property (@(posedge pclk) disable iff (!presetn) // R14
        rc_pulse[1] |=> rcause[PIF_R_PD])
        else $error("wake did not set power-down bit");
    chk_bor_cause: assert property (@(posedge pclk) disable iff (!presetn) // R14
        rc_pulse[0] |=> !rcause[PIF_R_BOR])
        else $error("brown-out cause not recorded");
endmodule : pif_flags
`default_nettype wire

//--- pif_periph_model.sv
// Purpose: on-chip peripheral side that raises event pulses and buffer levels
// Assumes: bench fire requests are one-cycle pulses, buffer requests are held levels, all launched on pclk
// Notes: one flop of delay, as a real peripheral's output register
`timescale 1ns/1ps
`default_nettype none
module pif_periph_model
    import pif_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [6:0] fire,
    input wire logic rx_req,
    input wire logic tx_req,
    output var pif_events_type events,
    output logic rx_buf_full,
    output logic tx_buf_empty
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            events <= '0;
        end else begin
            events <= pif_events_type'(fire);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_buf_full <= 1'b0;
            tx_buf_empty <= 1'b0;
        end else begin
            rx_buf_full <= rx_req;
            tx_buf_empty <= tx_req;
        end
    end
endmodule : pif_periph_model
`default_nettype wire

//--- tb_peripheral_irq_flags_reset_cause.sv
// Purpose: self-checking bench for the flag and reset-cause block
// Assumes: APB answers within a few cycles; events are one-cycle pulses
// Notes: expected flag values come from an integer model of the bench
`timescale 1ns/1ps
`default_nettype none
module tb_peripheral_irq_flags_reset_cause
    import pif_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic rx_req, tx_req, rx_buf_full, tx_buf_empty, prio_enable, sw_brownout_enable, irq;
    logic [6:0] fire;
    pif_events_type events;
    pif_ccp_mode_type ccp_mode;
    pif_rcause_ev_type rcause_ev;
    int bad_count, samples_checked, cycles, exp, rnd;
    int fb[7] = '{0, 1, 2, 2, 3, 6, 7};

    pif_flags i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .events(events), .ccp_mode(ccp_mode), .rx_buf_full(rx_buf_full),
        .tx_buf_empty(tx_buf_empty), .rcause_ev(rcause_ev), .prio_enable(prio_enable),
        .sw_brownout_enable(sw_brownout_enable), .irq(irq));
    pif_periph_model i_periph (.pclk(pclk), .presetn(presetn), .fire(fire), .rx_req(rx_req),
        .tx_req(tx_req), .events(events), .rx_buf_full(rx_buf_full),
        .tx_buf_empty(tx_buf_empty));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude

    task automatic check(input string name, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", name, e, g);
            bad_count++;
        end
    endtask : check

    // Request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the bench timeout ends a wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, PIF_ZERO32);
        check(name, e, rd);
    endtask : rd_chk

    task automatic pulse(input int i);
        @(posedge pclk);
        fire <= 7'h01 << i;
        @(posedge pclk);
        fire <= '0;
        repeat (3) @(posedge pclk);
    endtask : pulse

    // Cause inputs are held 4 cycles to pass the synchroniser
    task automatic cause(input logic [4:0] v, input logic [31:0] e);
        @(posedge pclk);
        rcause_ev <= pif_rcause_ev_type'(v);
        repeat (4) @(posedge pclk);
        rcause_ev <= '0;
        repeat (6) @(posedge pclk);
        rd_chk("rcause_ev", PIF_OFF_RCAUSE, e);
    endtask : cause

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            conclude();
        end
    end

    initial begin
        {presetn, psel, penable, pwrite, rx_req, tx_req} = '0;
        {paddr, pwdata, fire} = '0;
        ccp_mode = PIF_CCP_CAPTURE;
        rcause_ev = '0;
        rnd = $urandom(84094);
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk("flag_rst", PIF_OFF_FLAG1, 32'h0000_0000);
        rd_chk("rcause_rst", PIF_OFF_RCAUSE, 32'h0000_005C);
        rd_chk("mask_rst", PIF_OFF_MASK, 32'h0000_0000);
        rd_chk("istat_rst", PIF_OFF_ISTAT, 32'h0000_0000);
        check("prio_rst", 32'h0, prio_enable);
        check("sbor_rst", 32'h1, sw_brownout_enable);
        for (int m = 0; m < 3; m++) begin
            ccp_mode <= pif_ccp_mode_type'(m);
            for (int i = 0; i < 7; i++) begin
                rnd = $urandom;
                rx_req <= rnd[8];
                tx_req <= rnd[9];
                apb(1'b1, PIF_OFF_FLAG1, rnd);
                pulse(i);
                exp = (rnd & 32'h0000_00CF) | (rnd[8] << 5) | (rnd[9] << 4);
                if (!((i == 3 && m != 0) || (i == 2 && m != 1))) exp |= 1 << fb[i];
                rd_chk("flag_reg", PIF_OFF_FLAG1, exp);
            end
        end
        rx_req <= 1'b0;
        tx_req <= 1'b0;
        apb(1'b1, PIF_OFF_FLAG1, PIF_ZERO32);
        repeat (3) @(posedge pclk);
        apb(1'b0, PIF_OFF_ISTAT, PIF_ZERO32);
        apb(1'b1, PIF_OFF_MASK, 32'h0000_0001);
        rd_chk("mask", PIF_OFF_MASK, 32'h0000_0001);
        pulse(1);
        check("irq_masked", 32'h0, irq);
        pulse(0);
        check("irq_raised", 32'h1, irq);
        rd_chk("istat", PIF_OFF_ISTAT, 32'h0000_0003);
        repeat (2) @(posedge pclk);
        check("irq_cleared", 32'h0, irq);
        apb(1'b1, PIF_OFF_RCAUSE, 32'h0000_00A0);
        rd_chk("rcause_wr", PIF_OFF_RCAUSE, 32'h0000_008C);
        check("prio_on", 32'h1, prio_enable);
        check("sbor_off", 32'h0, sw_brownout_enable);
        apb(1'b1, PIF_OFF_RCAUSE, 32'h0000_00FF);
        rd_chk("rcause_ff", PIF_OFF_RCAUSE, 32'h0000_00DF);
        cause(5'b10000, 32'h0000_00CF);
        cause(5'b01000, 32'h0000_00C7);
        cause(5'b00100, 32'h0000_00C3);
        cause(5'b00010, 32'h0000_00C7);
        cause(5'b00001, 32'h0000_00C6);
        apb(1'b1, 8'h10, 32'hFFFF_FFFF);
        check("err_wr", 32'h1, err);
        apb(1'b0, 8'h10, PIF_ZERO32);
        check("err_rd", 32'h1, err);
        check("rd_unmapped", 32'h0, rd);
        conclude();
    end
endmodule : tb_peripheral_irq_flags_reset_cause
`default_nettype wire
